// >>> design/dbx_pkg.sv
package dbx_pkg;
    localparam int DBX_OP_W = 14;
    localparam int DBX_PC_W = 13;
    localparam int DBX_ADDR_W = 7;
    localparam int DBX_DATA_W = 8;
    localparam int DBX_LIT_W = 11;
    localparam int DBX_REGS = 128;
    // Opcode field and high-latch bit positions
    localparam int DBX_DEST_BIT = 7;
    localparam int DBX_LATCH_LO = 3;
    localparam int DBX_LATCH_HI = 4;
    // Opcode classes: top six bits for file ops, top three for the branch
    localparam logic [5:0] DBX_OPC_DECREMENT_FILE_OP = 6'h03;
    localparam logic [5:0] DBX_OPC_DECSZ = 6'h0B;
    localparam logic [2:0] DBX_OPC_BRANCH = 3'h5;
    // Reset values and the no-operation opcode
    localparam logic [12:0] DBX_PC_RST = 13'h0000;
    localparam logic [7:0] DBX_W_RST = 8'h00;
    localparam logic [7:0] DBX_LATCH_RST = 8'h00;
    localparam logic [7:0] DBX_FILE_RST = 8'h00;
    localparam logic [13:0] DBX_NOP = 14'h0000;

    typedef enum logic [3:0] {
        DBX_Q1 = 4'b0001,
        DBX_Q2 = 4'b0010,
        DBX_Q3 = 4'b0100,
        DBX_Q4 = 4'b1000
    } dbx_phase_e;

    typedef enum logic [2:0] {
        DBX_K_OTHER = 3'b001,
        DBX_K_DECREMENT_FILE_OP = 3'b010,
        DBX_K_DECSZ = 3'b100
    } dbx_kind_e;
endpackage

// >>> design/dbx_decode.sv
`timescale 1ns/10ps
module dbx_decode
    import dbx_pkg::*;
(
    input wire logic [dbx_pkg::DBX_OP_W-1:0] opcode,
    output logic is_decrement_file_op,
    output logic is_decsz,
    output logic is_branch,
    output logic dest_file,
    output logic [dbx_pkg::DBX_ADDR_W-1:0] file_addr,
    output logic [dbx_pkg::DBX_LIT_W-1:0] literal
);
    import dbx_pkg::*;

    always_comb begin
        is_decrement_file_op = opcode[13:8] == DBX_OPC_DECREMENT_FILE_OP;
        is_decsz = opcode[13:8] == DBX_OPC_DECSZ;
        is_branch = opcode[13:11] == DBX_OPC_BRANCH;
        dest_file = opcode[DBX_DEST_BIT];
        file_addr = opcode[DBX_ADDR_W-1:0];
        literal = opcode[DBX_LIT_W-1:0];
    end
endmodule

// >>> design/dbx_core.sv
`timescale 1ns/10ps
module dbx_core
    import dbx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [dbx_pkg::DBX_OP_W-1:0] instr,
    input wire logic [dbx_pkg::DBX_DATA_W-1:0] program_counter_high_latch,
    output logic [dbx_pkg::DBX_PC_W-1:0] pc,
    output logic [dbx_pkg::DBX_DATA_W-1:0] w_acc,
    output logic zero_flag,
    output logic [3:0] phase,
    output logic nop_cycle,
    output logic instr_done,
    output logic file_we,
    output logic [dbx_pkg::DBX_ADDR_W-1:0] file_waddr,
    output logic [dbx_pkg::DBX_DATA_W-1:0] file_wdata
);
    import dbx_pkg::*;

    typedef struct packed {
        dbx_phase_e ph;
        logic [DBX_PC_W-1:0] pc;
        logic [DBX_DATA_W-1:0] w;
        logic z;
        // Instruction fields latched at Q1; operand, result and write fields latched at Q2 to Q4
        logic br;
        logic [DBX_LIT_W-1:0] lit;
        dbx_kind_e kind;
        logic dest;
        logic [DBX_ADDR_W-1:0] addr;
        logic [DBX_DATA_W-1:0] opnd;
        logic [DBX_DATA_W-1:0] res;
        logic flush;
        logic nop;
        logic done;
        logic we;
        logic [DBX_ADDR_W-1:0] waddr;
        logic [DBX_DATA_W-1:0] wdata;
    } dbx_state_s;

    dbx_state_s st_reg;
    dbx_state_s st_next;
    logic [DBX_DATA_W-1:0] file_mem [DBX_REGS];
    logic d_decrement_file_op;
    logic d_decsz;
    logic d_branch;
    logic d_dest;
    logic [DBX_ADDR_W-1:0] d_addr;
    logic [DBX_LIT_W-1:0] d_lit;
    // Operand read and commit terms, derived from state and the program_counter_high_latch input
    logic [DBX_DATA_W-1:0] rd_data;
    logic res_zero;
    logic to_file;
    logic to_w;
    logic take_skip;
    logic take_branch;
    logic [DBX_PC_W-1:0] seq_pc;
    logic [DBX_PC_W-1:0] branch_pc;

    // Incoming word only decoded at Q1; latched instruction used later
    dbx_decode dbx_decode_i (
        .opcode(instr),
        .is_decrement_file_op(d_decrement_file_op),
        .is_decsz(d_decsz),
        .is_branch(d_branch),
        .dest_file(d_dest),
        .file_addr(d_addr),
        .literal(d_lit)
    );

    function automatic logic [DBX_PC_W-1:0] dbx_pc_inc(input logic [DBX_PC_W-1:0] v);
        dbx_pc_inc = v + 13'h0001;
    endfunction

    function automatic logic dbx_is_zero(input logic [DBX_DATA_W-1:0] v);
        dbx_is_zero = v == 8'h00;
    endfunction

    function automatic logic [DBX_DATA_W-1:0] dbx_dec(input logic [DBX_DATA_W-1:0] v);
        dbx_dec = v - 8'h01;
    endfunction

    function automatic dbx_kind_e dbx_kind_of(input logic flush, input logic decrement_file_op,
        input logic decsz);
        if (flush) begin
            dbx_kind_of = DBX_K_OTHER;
        end else if (decrement_file_op) begin
            dbx_kind_of = DBX_K_DECREMENT_FILE_OP;
        end else if (decsz) begin
            dbx_kind_of = DBX_K_DECSZ;
        end else begin
            dbx_kind_of = DBX_K_OTHER;
        end
    endfunction

    // Operand read used in Q2, commit decisions from the latched instruction used in Q4
    always_comb begin
        rd_data = file_mem[st_reg.addr];
        res_zero = dbx_is_zero(st_reg.res);
        to_file = st_reg.kind != DBX_K_OTHER && st_reg.dest;
        to_w = st_reg.kind != DBX_K_OTHER && !st_reg.dest;
        take_skip = st_reg.kind == DBX_K_DECSZ && res_zero;
        take_branch = st_reg.br && !st_reg.nop;
        // Flushed slot holds the counter so a skip or branch lands exactly
        seq_pc = st_reg.nop ? st_reg.pc : dbx_pc_inc(st_reg.pc);
        branch_pc = {program_counter_high_latch[DBX_LATCH_HI:DBX_LATCH_LO],
            st_reg.lit};
    end

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.we = 1'b0;
        case (st_reg.ph)
            DBX_Q1: begin
                st_next.ph = DBX_Q2;
                // Flushed slot runs as a no-operation
                st_next.br = !st_reg.flush && d_branch;
                st_next.lit = d_lit;
                st_next.nop = st_reg.flush;
                st_next.flush = 1'b0;
                st_next.kind = dbx_kind_of(st_reg.flush, d_decrement_file_op, d_decsz);
                st_next.dest = d_dest;
                st_next.addr = d_addr;
            end

            DBX_Q2: begin
                // Operand read one phase after decode
                st_next.ph = DBX_Q3;
                st_next.opnd = rd_data;
            end

            DBX_Q3: begin
                // Wraps from 00 to FF
                st_next.ph = DBX_Q4;
                st_next.res = dbx_dec(st_reg.opnd);
            end

            DBX_Q4: begin
                st_next.ph = DBX_Q1;
                st_next.done = 1'b1;
                st_next.pc = seq_pc;
                if (to_file) begin
                    st_next.we = 1'b1;
                    st_next.waddr = st_reg.addr;
                    st_next.wdata = st_reg.res;
                end

                if (to_w) begin
                    st_next.w = st_reg.res;
                end

                if (st_reg.kind == DBX_K_DECREMENT_FILE_OP) begin
                    st_next.z = res_zero;
                end

                if (take_skip) begin
                    // Counter moves past the skipped word now
                    st_next.pc = dbx_pc_inc(dbx_pc_inc(st_reg.pc));
                    st_next.flush = 1'b1;
                end

                if (take_branch) begin
                    st_next.pc = branch_pc;
                    st_next.flush = 1'b1;
                end
            end
            default: begin
                st_next.ph = DBX_Q1;
            end
        endcase
        if (!resetn) begin
            st_next = '0;
            st_next.ph = DBX_Q1;
            st_next.kind = DBX_K_OTHER;
            st_next.pc = DBX_PC_RST;
            st_next.w = DBX_W_RST;
            // A pending flush must not swallow the first word after reset
            st_next.flush = 1'b0;
            st_next.nop = 1'b0;
            st_next.z = 1'b0;
            st_next.done = 1'b0;
            st_next.we = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st_reg <= st_next;
    end

    // Cleared on reset so counts built by decrements are known values
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            for (int i = 0; i < DBX_REGS; i++) begin
                file_mem[i] <= DBX_FILE_RST;
            end
        end else if (st_reg.ph == DBX_Q4 && to_file) begin
            file_mem[st_reg.addr] <= st_reg.res;
        end
    end

    // Outputs are plain copies of state flip-flops
    always_comb begin
        pc = st_reg.pc;
        w_acc = st_reg.w;
        zero_flag = st_reg.z;
        phase = st_reg.ph;
        nop_cycle = st_reg.nop;
        instr_done = st_reg.done;
        file_we = st_reg.we;
        file_waddr = st_reg.waddr;
        file_wdata = st_reg.wdata;
    end
endmodule

// >>> bench/dbx_core_chk.sv
`timescale 1ns/10ps
module dbx_core_chk
    import dbx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [dbx_pkg::DBX_OP_W-1:0] instr,
    input wire logic [dbx_pkg::DBX_DATA_W-1:0] program_counter_high_latch,
    input wire logic [dbx_pkg::DBX_PC_W-1:0] pc,
    input wire logic [3:0] phase,
    input wire logic nop_cycle,
    input wire logic instr_done,
    input wire logic file_we,
    input wire logic [dbx_pkg::DBX_ADDR_W-1:0] file_waddr,
    input wire logic [dbx_pkg::DBX_DATA_W-1:0] file_wdata,
    input wire logic [dbx_pkg::DBX_DATA_W-1:0] w_acc,
    input wire logic zero_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Flushed slots also end in Q1, so look back at their Q3
    sequence s_real; instr_done && !$past(nop_cycle, 2); endsequence
    sequence s_decrement_file_op; s_real ##0 $past(instr[13:8], 4) == DBX_OPC_DECREMENT_FILE_OP; endsequence
    sequence s_decsz; s_real ##0 $past(instr[13:8], 4) == DBX_OPC_DECSZ; endsequence
    property p_quad;
        phase == 4'h1 |=> phase == 4'h2 ##1 phase == 4'h4 ##1 phase == 4'h8 ##1 instr_done;
    endproperty
    a_quad: assert property (p_quad) else $error("phase order");
    property p_decrement_file_op_pc; s_decrement_file_op |-> pc == $past(pc) + 13'h1; endproperty
    a_decrement_file_op_pc: assert property (p_decrement_file_op_pc) else $error("pc after decrement");
    property p_to_file;
        s_decrement_file_op ##0 $past(instr[7], 4) |-> file_we && file_waddr == $past(instr[6:0], 4);
    endproperty
    a_to_file: assert property (p_to_file) else $error("file write");
    property p_to_w; s_decrement_file_op ##0 !$past(instr[7], 4) |-> !file_we; endproperty
    a_to_w: assert property (p_to_w) else $error("file touched");
    property p_zero_file;
        s_decrement_file_op ##0 $past(instr[7], 4) |-> zero_flag == (file_wdata == 8'h00);
    endproperty
    a_zero_file: assert property (p_zero_file) else $error("zero flag file");
    property p_zero_w;
        s_decrement_file_op ##0 !$past(instr[7], 4) |-> zero_flag == (w_acc == 8'h00);
    endproperty
    a_zero_w: assert property (p_zero_w) else $error("zero flag acc");
    property p_skip;
        s_decsz |-> (pc == $past(pc) + 13'h1 ##1 !nop_cycle)
            or (pc == $past(pc) + 13'h2 ##1 nop_cycle [*4]);
    endproperty
    a_skip: assert property (p_skip) else $error("skip");
    property p_decsz_we; s_decsz |-> file_we == $past(instr[7], 4); endproperty
    a_decsz_we: assert property (p_decsz_we) else $error("skip dest");
    property p_branch;
        s_real ##0 $past(instr[13:11], 4) == DBX_OPC_BRANCH |->
            pc == {$past(program_counter_high_latch[4:3]), $past(instr[10:0], 4)}
            ##1 nop_cycle [*4];
    endproperty
    a_branch: assert property (p_branch) else $error("branch");
endmodule

bind dbx_core dbx_core_chk dbx_core_chk_i (.clk_sys, .resetn, .instr,
    .program_counter_high_latch, .pc, .phase, .nop_cycle, .instr_done, .file_we, .file_waddr,
    .file_wdata, .w_acc, .zero_flag);

// >>> bench/test_dbx_core.sv
`timescale 1ns/10ps
module test_dbx_core;
    import dbx_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [DBX_OP_W-1:0] instr = DBX_NOP;
    logic [DBX_DATA_W-1:0] latch = 8'h2C;
    logic [DBX_PC_W-1:0] pc;
    logic [DBX_DATA_W-1:0] w_acc, file_wdata;
    logic zero_flag, nop_cycle, instr_done, file_we;
    logic [3:0] phase;
    logic [DBX_ADDR_W-1:0] file_waddr;
    int err_total = 0;
    int n_tests = 0;
    always #20 clk_sys = ~clk_sys;
    dbx_core dbx_core_i (.clk_sys, .resetn, .instr, .program_counter_high_latch(latch),
        .pc, .w_acc, .zero_flag, .phase, .nop_cycle, .instr_done, .file_we, .file_waddr,
        .file_wdata);
    task complete_run;
        if (err_total == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task issue(input logic [13:0] op, input logic we);
        for (int i = 0; i < 8 && phase !== 4'h1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (phase !== 4'h1) begin
            err_total++;
            complete_run();
        end
        instr = op;
        repeat (4) @(posedge clk_sys);
        #1;
        chk({instr_done, file_we}, {14'h0, 1'b1, we}, "done or write");
    endtask
    task decrement_file_op_to_file;
        issue(14'h03A5, 1'b1);
        chk(file_waddr, 16'h25, "waddr");
        chk(pc, 16'h1, "pc step");
        chk(file_wdata, 16'hFF, "file data");
        chk(zero_flag, 16'h0, "zero clear");
    endtask
    task decrement_file_op_to_w;
        issue(14'h037F, 1'b0);
        chk(pc, 16'h2, "pc step");
        chk(w_acc, 16'hFF, "acc data");
    endtask
    task branch_flush;
        issue(14'h2FFF, 1'b0);
        chk(pc, 16'h0FFF, "branch target");
        // Slot after the branch must be swallowed
        instr = 14'h0391;
        repeat (4) @(posedge clk_sys);
        #1;
        chk({file_we, nop_cycle, pc}, 16'h2FFF, "flushed slot");
        issue(14'h03D1, 1'b1);
        chk(pc, 16'h1000, "after flush");
        issue(14'h0391, 1'b1);
        chk(file_wdata, 16'hFF, "slot left file");
    endtask
    task decsz_op;
        for (int i = 0; i < 255; i++) begin
            issue(14'h0B80, 1'b1);
        end
        chk(file_wdata, 16'h1, "count down");
        chk(pc, 16'h1100, "no skip");
        issue(14'h0300, 1'b0);
        chk({w_acc, 7'h0, zero_flag}, 16'h0001, "zero to acc");
        issue(14'h0B80, 1'b1);
        chk(file_wdata, 16'h0, "file kept");
        chk(pc, 16'h1103, "skip");
        instr = 14'h0B80;
        repeat (4) @(posedge clk_sys);
        #1;
        chk({file_we, nop_cycle, pc}, 16'h3103, "skipped slot");
        issue(14'h0B80, 1'b1);
        chk(file_wdata, 16'hFF, "slot swallowed");
        chk(file_waddr, 16'h0, "skip waddr");
        chk(pc, 16'h1104, "after skip");
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        chk(pc, 16'h0, "reset pc");
        chk({w_acc, zero_flag, phase}, 16'h1, "reset state");
        decrement_file_op_to_file();
        decrement_file_op_to_w();
        branch_flush();
        decsz_op();
        complete_run();
    end
endmodule
